// File: src/pci_err_cfg.svh
// offsets, field positions, reset values and timing counts of the error unit
`ifndef PCI_ERR_CFG_SVH
`define PCI_ERR_CFG_SVH
`define PE_AW 8
`define PE_OFS_MIRROR 8'h00
`define PE_OFS_STAT_SET 8'h04
`define PE_OFS_STAT_CLR 8'h08
`define PE_OFS_HOST_EN 8'h0c
`define PE_OFS_LOCAL_EN 8'h10
// command/status register fields
`define PE_CSR_IO_EN 0
`define PE_CSR_MEM_EN 1
`define PE_CSR_MST_EN 2
`define PE_CSR_PAR_RESP 6
`define PE_CSR_SYSTEM_ERROR_PIN_ENABLE 8
`define PE_CSR_MST_PAR 24
`define PE_CSR_SIG_TABRT 27
`define PE_CSR_RCV_TABRT 28
`define PE_CSR_RCV_MABRT 29
`define PE_CSR_SIG_SERR 30
`define PE_CSR_DET_PAR 31
`define PE_CSR_CMD_MASK 32'h0000_0147
`define PE_CSR_STAT_MASK 32'hf900_0000
`define PE_CSR_RESET 32'h0000_0000
// internal status register fields
`define PE_IST_W 5
`define PE_IST_SOFT 0
`define PE_IST_PERR 1
`define PE_IST_SERR 2
`define PE_IST_MABRT 3
`define PE_IST_TABRT 4
`define PE_IST_RESET 5'h00
`define PE_EN_RESET 5'h00
// perr pin stays driven for this many link clock edges after the error
`define PE_PERR_HOLD 2'h2
`define PE_SERR_HOLD 2'h1
`endif

// File: src/pci_err_pkg.sv
// types shared by the error unit
package pci_err_pkg;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_BUS_END,
    ST_LOCAL_END,
    ST_HALT
  } term_state_t;
  typedef logic [3:0] byte_en_t;
endpackage : pci_err_pkg

// File: src/pin_sync.sv
// two-stage pin synchroniser
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // asynchronous pins and their synchronised copies
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end
        else
        begin
          meta_r <= i_async[g];
          sync_r <= meta_r;
        end
      end
      assign o_sync[g] = sync_r;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// File: src/axil_regif.sv
// axi4-lite slave front end: one write and one read at a time
`include "pci_err_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module axil_regif (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // axi4-lite write channels
  input wire logic [`PE_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read channels
  input wire logic [`PE_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // register side
  output logic o_wr,
  output logic [`PE_AW-1:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  input wire logic i_wr_hit,
  output logic [`PE_AW-1:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_hit
);
  logic aw_full_r;
  logic w_full_r;
  assign o_awready = !aw_full_r && !o_bvalid;
  assign o_wready = !w_full_r && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign o_rd_addr = i_araddr;
  // the write fires in the cycle that both halves are held
  assign o_wr = aw_full_r && w_full_r && !o_bvalid;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      o_wr_addr <= '0;
      o_wr_data <= 32'h0000_0000;
      o_wr_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_full_r <= 1'b1;
        o_wr_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready)
      begin
        w_full_r <= 1'b1;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (o_wr)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= i_wr_hit ? 2'h0 : 2'h2;
      end
      else if (o_bvalid && i_bready)
        o_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rdata <= i_rd_hit ? i_rd_data : 32'h0000_0000;
      o_rresp <= i_rd_hit ? 2'h0 : 2'h2;
    end
    else if (o_rvalid && i_rready)
      o_rvalid <= 1'b0;
  end
endmodule : axil_regif
`default_nettype wire

// File: src/pci_err_status.sv
// error detection, status reporting and interrupts of the pci agent
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`include "pci_err_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
// Function
// - byte enables for 1 to 4 byte accesses
// - words align to 00, halfwords to 0
// - target any address, master word aligned
// - master parity flag on read error or perr
// - detected flag: master read, target write, address
// - perr pin needs enable and flag, held two clocks
// - parity errors never abort
// - system flag: address error, perr or target abort
// - serr pin on enable and flag, sets signaled bit
// - after serr the unit halts until reset
// - master abort ends bus and local sides cleanly
// - target abort ends like a master abort
// - retry reissues from first undone word, silently
// - csr via host config and local mirror
// - csr status set by hardware, write one clears
// - five-bit status, set and clear ports read it
// - status reached only through those ports
// - status and csr bits never affect each other
// - enabled status bits raise host and local irqs
// - flag own master abort and issued target abort
// - flag data parity and system error exceptions
// - logic follows the link clock, at most 33 mhz
module pci_err_status
  import pci_err_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  // link pins
  input wire logic i_link_clk,
  input wire logic i_parity_error_pin_n,
  output logic o_parity_error_pin_n,
  output logic o_parity_error_pin_oe_n,
  output logic o_system_error_pin_n,
  output logic o_system_error_pin_oe_n,
  output logic o_host_interrupt_pin_n,
  output logic o_host_interrupt_pin_oe_n,
  output logic o_frame_release,
  output logic o_initiator_ready_force,
  // bus engine events, one-cycle pulses unless noted
  input wire logic i_mst_active,
  input wire logic i_mst_read,
  input wire logic i_tgt_active,
  input wire logic i_tgt_read,
  input wire logic i_data_parity_bad,
  input wire logic i_addr_parity_bad,
  input wire logic i_mst_abort,
  input wire logic i_tgt_abort_rcvd,
  input wire logic i_tgt_abort_issued,
  input wire logic i_retry,
  input wire logic i_disconnect,
  input wire logic i_mst_start,
  input wire logic [31:0] i_mst_addr,
  input wire logic i_mst_word_done,
  input wire logic i_burst_done,
  // target access byte lanes
  input wire logic [1:0] i_tgt_addr_lo,
  input wire logic [1:0] i_tgt_size,
  output byte_en_t o_tgt_be,
  output logic o_tgt_misaligned,
  // master engine control
  output logic [31:0] o_mst_addr,
  output logic o_reissue,
  output logic [31:0] o_reissue_addr,
  output logic o_local_ready,
  output logic o_halted,
  output logic o_local_irq,
  // host configuration access to the command/status register
  input wire logic i_cfg_wr,
  input wire logic [3:0] i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  // axi4-lite register bus
  input wire logic [`PE_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`PE_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  logic [1:0] sync_out;
  logic link_clk_s;
  logic perr_in_n_s;
  logic link_clk_d_r;
  logic link_rise;
  logic wr;
  logic [`PE_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [`PE_AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] csr_cmd_r;
  logic [31:0] csr_stat_r;
  logic [31:0] csr_stat_set;
  logic [31:0] csr_stat_clr;
  logic [31:0] cfg_mask;
  logic [31:0] axi_mask;
  logic [`PE_IST_W-1:0] ist_r;
  logic [`PE_IST_W-1:0] ist_hw_set;
  logic [`PE_IST_W-1:0] host_en_r;
  logic [`PE_IST_W-1:0] local_en_r;
  logic [1:0] perr_cnt_r;
  logic [1:0] serr_cnt_r;
  logic sys_flag_r;
  logic mst_rd_perr;
  logic tgt_wr_perr;
  logic perr_pin_seen;
  logic data_perr;
  logic par_resp;
  logic serr_fire;
  logic term_start;
  logic run;
  logic [31:0] mst_base_r;
  logic [29:0] words_done_r;
  term_state_t state_r;
  term_state_t state_nxt;

  // link clock and perr pass the synchroniser
  pin_sync #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_link_clk, i_parity_error_pin_n}),
    .o_sync(sync_out)
  );
  assign link_clk_s = sync_out[1];
  assign perr_in_n_s = sync_out[0];

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      link_clk_d_r <= 1'b1;
    else
      link_clk_d_r <= link_clk_s;
  end
  // pin timing counts link clock edges, never system cycles
  assign link_rise = link_clk_s && !link_clk_d_r;

  axil_regif u_regif (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .o_wr(wr),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_hit(wr_hit),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_hit(rd_hit)
  );

  // byte lane masks for host config writes and for axi writes
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask
  assign cfg_mask = lane_mask(i_cfg_be);
  assign axi_mask = lane_mask(wr_strb);

  // event decode; a halted unit ignores all further parity, abort, retry and disconnect events
  assign run = (state_r != ST_HALT);
  assign mst_rd_perr = run && i_mst_active && i_mst_read && i_data_parity_bad;
  assign tgt_wr_perr = run && i_tgt_active && !i_tgt_read
    && i_data_parity_bad;
  assign perr_pin_seen = run && link_rise && !perr_in_n_s && i_mst_active;
  assign data_perr = mst_rd_perr || tgt_wr_perr;
  assign par_resp = csr_cmd_r[`PE_CSR_PAR_RESP];

  // command bits: host config and mirror writes, byte lanes honoured
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      csr_cmd_r <= `PE_CSR_RESET;
    else if (i_cfg_wr)
      csr_cmd_r <= (csr_cmd_r & ~(cfg_mask & `PE_CSR_CMD_MASK))
        | (i_cfg_wdata & cfg_mask & `PE_CSR_CMD_MASK);
    else if (wr && wr_addr == `PE_OFS_MIRROR)
      csr_cmd_r <= (csr_cmd_r & ~(axi_mask & `PE_CSR_CMD_MASK))
        | (wr_data & axi_mask & `PE_CSR_CMD_MASK);
  end

  // status bits of the command/status register
  always_comb
  begin
    csr_stat_set = 32'h0000_0000;
    csr_stat_set[`PE_CSR_MST_PAR] = mst_rd_perr
      || (perr_pin_seen && !i_mst_read);
    csr_stat_set[`PE_CSR_DET_PAR] = data_perr
      || (run && i_addr_parity_bad);
    csr_stat_set[`PE_CSR_SIG_SERR] = serr_fire;
    csr_stat_set[`PE_CSR_RCV_MABRT] = run && i_mst_active
      && i_mst_abort;
    csr_stat_set[`PE_CSR_RCV_TABRT] = run && i_mst_active
      && i_tgt_abort_rcvd;
    csr_stat_set[`PE_CSR_SIG_TABRT] = run && i_tgt_abort_issued;
    csr_stat_clr = 32'h0000_0000;
    if (i_cfg_wr)
      csr_stat_clr = i_cfg_wdata & cfg_mask;
    if (wr && wr_addr == `PE_OFS_MIRROR)
      csr_stat_clr = csr_stat_clr | (wr_data & axi_mask);
  end

  // writes only clear; a hardware set in the same cycle wins
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      csr_stat_r <= `PE_CSR_RESET;
    else
      csr_stat_r <= ((csr_stat_r & ~csr_stat_clr) | csr_stat_set)
        & `PE_CSR_STAT_MASK;
  end

  // internal status: ports and own events only
  always_comb
  begin
    ist_hw_set = `PE_IST_RESET;
    ist_hw_set[`PE_IST_PERR] = data_perr;
    ist_hw_set[`PE_IST_SERR] = (run && i_mst_active && i_tgt_abort_rcvd)
      || (run && i_addr_parity_bad);
    ist_hw_set[`PE_IST_MABRT] = run && i_mst_active && i_mst_abort;
    ist_hw_set[`PE_IST_TABRT] = run && i_tgt_abort_issued;
  end

  // csr writes never touch this register
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ist_r <= `PE_IST_RESET;
    else if (wr && wr_addr == `PE_OFS_STAT_SET && wr_strb[0])
      ist_r <= ist_r | wr_data[`PE_IST_W-1:0] | ist_hw_set;
    else if (wr && wr_addr == `PE_OFS_STAT_CLR && wr_strb[0])
      ist_r <= (ist_r & ~wr_data[`PE_IST_W-1:0]) | ist_hw_set;
    else
      ist_r <= ist_r | ist_hw_set;
  end

  // interrupt enables, one per destination
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      host_en_r <= `PE_EN_RESET;
      local_en_r <= `PE_EN_RESET;
    end
    else if (wr && wr_strb[0])
    begin
      if (wr_addr == `PE_OFS_HOST_EN)
        host_en_r <= wr_data[`PE_IST_W-1:0];
      if (wr_addr == `PE_OFS_LOCAL_EN)
        local_en_r <= wr_data[`PE_IST_W-1:0];
    end
  end

  // register read mux; both set and clear ports read the internal status
  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `PE_OFS_MIRROR: rd_data = csr_cmd_r | csr_stat_r;
      `PE_OFS_STAT_SET: rd_data[`PE_IST_W-1:0] = ist_r;
      `PE_OFS_STAT_CLR: rd_data[`PE_IST_W-1:0] = ist_r;
      `PE_OFS_HOST_EN: rd_data[`PE_IST_W-1:0] = host_en_r;
      `PE_OFS_LOCAL_EN: rd_data[`PE_IST_W-1:0] = local_en_r;
      default: rd_hit = 1'b0;
    endcase
  end
  assign wr_hit = (wr_addr == `PE_OFS_MIRROR)
    || (wr_addr == `PE_OFS_STAT_SET) || (wr_addr == `PE_OFS_STAT_CLR)
    || (wr_addr == `PE_OFS_HOST_EN) || (wr_addr == `PE_OFS_LOCAL_EN);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_cfg_rdata <= 32'h0000_0000;
    else
      o_cfg_rdata <= csr_cmd_r | csr_stat_r;
  end

  // perr pin: response must be enabled and the detected flag raised
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      perr_cnt_r <= 2'h0;
    else if (data_perr && par_resp)
      perr_cnt_r <= `PE_PERR_HOLD;
    else if (link_rise && perr_cnt_r != 2'h0)
      perr_cnt_r <= perr_cnt_r - 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_parity_error_pin_n <= 1'b1;
      o_parity_error_pin_oe_n <= 1'b1;
    end
    else
    begin
      o_parity_error_pin_n <= 1'b0;
      o_parity_error_pin_oe_n <= !(perr_cnt_r != 2'h0 && par_resp
        && csr_stat_r[`PE_CSR_DET_PAR]);
    end
  end

  // internal system error flag holds until reset
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      sys_flag_r <= 1'b0;
    else if ((run && i_addr_parity_bad && par_resp) || perr_pin_seen
      || (run && i_mst_active && i_tgt_abort_rcvd))
      sys_flag_r <= 1'b1;
  end

  // serr is driven for one link clock period; the unit halts as soon as it fires
  assign serr_fire = run && sys_flag_r && csr_cmd_r[`PE_CSR_SYSTEM_ERROR_PIN_ENABLE]
    && serr_cnt_r == 2'h0;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      serr_cnt_r <= 2'h0;
    else if (serr_fire)
      serr_cnt_r <= `PE_SERR_HOLD;
    else if (link_rise && serr_cnt_r != 2'h0)
      serr_cnt_r <= serr_cnt_r - 2'h1;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_system_error_pin_n <= 1'b1;
      o_system_error_pin_oe_n <= 1'b1;
    end
    else
    begin
      o_system_error_pin_n <= 1'b0;
      o_system_error_pin_oe_n <= !(serr_cnt_r != 2'h0);
    end
  end

  // abort termination; parity errors deliberately do not enter here
  assign term_start = run && i_mst_active
    && (i_mst_abort || i_tgt_abort_rcvd);
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (serr_fire)
          state_nxt = ST_HALT;
        else if (term_start)
          state_nxt = ST_BUS_END;
      ST_BUS_END:
        if (serr_fire)
          state_nxt = ST_HALT;
        else if (link_rise)
          state_nxt = i_burst_done ? ST_RUN : ST_LOCAL_END;
      ST_LOCAL_END:
        if (serr_fire)
          state_nxt = ST_HALT;
        else if (i_burst_done)
          state_nxt = ST_RUN;
      ST_HALT:
        state_nxt = ST_HALT;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // bus side ends in one link period; local ready to burst end
  assign o_frame_release = (state_r == ST_BUS_END);
  assign o_initiator_ready_force = (state_r == ST_BUS_END);
  assign o_local_ready = (state_r == ST_BUS_END)
    || (state_r == ST_LOCAL_END);
  assign o_halted = (state_r == ST_HALT);

  // reissue point tracking; the local requester never sees a retry
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mst_base_r <= 32'h0000_0000;
      words_done_r <= 30'h0000_0000;
    end
    else if (i_mst_start)
    begin
      mst_base_r <= {i_mst_addr[31:2], 2'h0};
      words_done_r <= 30'h0000_0000;
    end
    else if (i_mst_word_done)
      words_done_r <= words_done_r + 30'h0000_0001;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_reissue <= 1'b0;
      o_reissue_addr <= 32'h0000_0000;
      o_mst_addr <= 32'h0000_0000;
    end
    else
    begin
      o_reissue <= run && i_mst_active && (i_retry || i_disconnect);
      o_reissue_addr <= mst_base_r + {words_done_r, 2'h0};
      o_mst_addr <= {i_mst_addr[31:2], 2'h0};
    end
  end

  // size 0..3 means 1..4 bytes from the low address
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_tgt_be <= 4'h0;
      o_tgt_misaligned <= 1'b0;
    end
    else
    begin
      o_tgt_be <= 4'(({1'b0, 4'hf} >> (3'h3 - {1'b0, i_tgt_size}))
        << i_tgt_addr_lo);
      o_tgt_misaligned <= (i_tgt_size == 2'h3 && i_tgt_addr_lo != 2'h0)
        || (i_tgt_size == 2'h1 && i_tgt_addr_lo[0])
        || ({1'b0, i_tgt_size} + {1'b0, i_tgt_addr_lo} > 3'h3);
    end
  end

  // interrupts are levels that follow the enabled status bits
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_host_interrupt_pin_oe_n <= 1'b1;
      o_local_irq <= 1'b0;
    end
    else
    begin
      o_host_interrupt_pin_oe_n <= !(|(ist_r & host_en_r));
      o_local_irq <= |(ist_r & local_en_r);
    end
  end
  assign o_host_interrupt_pin_n = 1'b0;
endmodule : pci_err_status
`default_nettype wire

// File: testbench/pci_err_status_asserts.sv
// port assertions of the pci error unit
`timescale 1ns/10ps
`default_nettype none
module pci_err_status_asserts (
  // watched ports
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_mst_start,
  input wire logic i_mst_active,
  input wire logic i_retry,
  input wire logic i_disconnect,
  input wire logic [31:0] i_mst_addr,
  input wire logic [31:0] o_mst_addr,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic o_reissue,
  input wire logic o_halted,
  input wire logic o_frame_release,
  input wire logic o_initiator_ready_force,
  input wire logic o_local_ready,
  input wire logic o_parity_error_pin_n,
  input wire logic o_parity_error_pin_oe_n,
  input wire logic o_system_error_pin_oe_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_mst_align: assert property (i_mst_start && !o_halted |=>
    o_mst_addr == {$past(i_mst_addr[31:2]), 2'b00}) else $error("addr");
  a_bus_end: assert property (o_frame_release |->
    o_initiator_ready_force && o_local_ready) else $error("bus end");
  a_retry_again: assert property (i_mst_active && !o_halted &&
    (i_retry || i_disconnect) |=> o_reissue) else $error("reissue");
  a_halt_quiet: assert property (o_halted |->
    !o_reissue && !o_frame_release) else $error("halt");
  a_perr_gate: assert property (!o_parity_error_pin_oe_n |->
    !o_parity_error_pin_n && o_cfg_rdata[6]) else $error("perr");
  a_serr_gate: assert property (!o_system_error_pin_oe_n |->
    o_cfg_rdata[8]) else $error("serr enable");
  a_serr_sig: assert property ($fell(o_system_error_pin_oe_n) |->
    ##[0:3] o_cfg_rdata[30]) else $error("serr flag");
  a_serr_halt: assert property ($fell(o_system_error_pin_oe_n) |->
    ##[1:40] o_halted) else $error("no halt");
endmodule : pci_err_status_asserts
bind pci_err_status pci_err_status_asserts chk_u (.*);
`default_nettype wire

// File: testbench/pci_link_model.sv
// far-side agent: link clock and the pulled-up perr line
`timescale 1ns/10ps
`default_nettype none
module pci_link_model (
  // bench request and unit drive
  input wire logic i_req,
  input wire logic i_pin_n,
  input wire logic i_oe_n,
  // link clock and resolved line
  output logic o_clk,
  output logic o_line_n
);
  logic drv_r;
  // the bus clock runs free, well under the 33 mhz ceiling
  initial
  begin
    o_clk = 1'b0;
    drv_r = 1'b0;
    forever
    begin
      #80 o_clk = ~o_clk;
      if (o_clk)
        drv_r = i_req;
    end
  end
  // released line floats back to the pull-up
  assign o_line_n = !(drv_r || (!i_oe_n && !i_pin_n));
endmodule : pci_link_model
`default_nettype wire

// File: testbench/tb_pci_err_status.sv
// bench of the pci error unit
`timescale 1ns/10ps
`default_nettype none
module tb_pci_err_status;
  import pci_err_pkg::*;
  logic i_clk, i_arst_n, i_link_clk, i_parity_error_pin_n, perr_req;
  logic o_parity_error_pin_n, o_parity_error_pin_oe_n, o_system_error_pin_n;
  logic o_system_error_pin_oe_n, o_host_interrupt_pin_n, o_local_irq;
  logic o_host_interrupt_pin_oe_n, o_frame_release, o_initiator_ready_force;
  logic i_mst_active, i_mst_read, i_tgt_active, i_tgt_read, i_cfg_wr;
  logic o_reissue, o_local_ready, o_halted, o_tgt_misaligned, o_awready;
  logic o_wready, o_bvalid, o_arready, o_rvalid, i_awvalid, i_wvalid;
  logic i_bready, i_arvalid, i_rready;
  logic [1:0] i_tgt_addr_lo, i_tgt_size, o_bresp, o_rresp;
  logic [3:0] i_cfg_be, i_wstrb;
  byte_en_t o_tgt_be;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_mst_addr, o_mst_addr, o_reissue_addr, i_cfg_wdata, o_rdata;
  logic [31:0] o_cfg_rdata, i_wdata, v;
  logic [9:0] ev;
  logic [33:0] q[$];
  int n_fail = 0, compares = 0, seed = 13, i;
  int aev[4] = '{2, 3, 4, 1};
  logic [31:0] acs[4] = '{32'h2000_0000, 32'h1000_0000, 32'h0800_0000,
    32'h8000_0000};
  logic [4:0] ais[4] = '{5'h08, 5'h04, 5'h10, 5'h04};
  pci_err_status dut_u (.*, .i_data_parity_bad(ev[0]),
    .i_addr_parity_bad(ev[1]), .i_mst_abort(ev[2]), .i_tgt_abort_rcvd(ev[3]),
    .i_tgt_abort_issued(ev[4]), .i_retry(ev[5]), .i_disconnect(ev[6]),
    .i_mst_start(ev[7]), .i_mst_word_done(ev[8]), .i_burst_done(ev[9]));
  pci_link_model link_u (.i_req(perr_req), .i_pin_n(o_parity_error_pin_n),
    .i_oe_n(o_parity_error_pin_oe_n), .o_clk(i_link_clk),
    .o_line_n(i_parity_error_pin_n));
  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge i_clk);
    @(negedge i_clk);
  endtask : cyc
  task pulse(input int b);
    @(posedge i_clk);
    ev[b] <= 1'b1;
    @(posedge i_clk);
    ev[b] <= 1'b0;
  endtask : pulse
  task cfg(input logic [31:0] d);
    @(posedge i_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    cyc(2);
  endtask : cfg
  // reads queue their expectation
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int n;
    logic [4:0] t;
    @(posedge i_clk);
    i_awaddr <= a;
    i_araddr <= a;
    i_wdata <= d;
    {i_awvalid, i_wvalid, i_bready} <= {3{w}};
    {i_arvalid, i_rready} <= {2{!w}};
    if (!w)
      q.push_back(e);
    n = 0;
    do
    begin
      @(negedge i_clk);
      t = {i_awvalid && o_awready, i_wvalid && o_wready, i_bready && o_bvalid,
        i_arvalid && o_arready, i_rready && o_rvalid};
      if (t[2])
        chk("bresp", e, {o_bresp, 32'h0});
      @(posedge i_clk);
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} <=
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} & ~t;
      n++;
    end while (n < 50 &&
      (i_awvalid || i_wvalid || i_bready || i_arvalid || i_rready));
    if (n >= 50)
    begin
      n_fail++;
      $display("Error bus_wait exp answer got none");
      conclude();
    end
  endtask : bus
  always @(negedge i_clk)
    if (o_rvalid && i_rready && q.size() > 0)
      chk("rdata", q.pop_front(), {o_rresp, o_rdata});
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    {i_arst_n, perr_req, i_mst_active, i_mst_read, i_tgt_active} = '0;
    {i_tgt_read, i_cfg_wr, i_awvalid, i_wvalid, i_bready} = '0;
    {i_arvalid, i_rready, i_tgt_addr_lo, i_tgt_size, ev} = '0;
    {i_awaddr, i_araddr, i_mst_addr, i_cfg_wdata, i_wdata} = '0;
    i_cfg_be = 4'hf;
    i_wstrb = 4'hf;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    bus(0, 8'h10, 0, 0);
    bus(0, 8'h20, 0, {2'b10, 32'h0});
    bus(1, 8'h20, 0, {2'b10, 32'h0});
    cfg(32'hffff_feff);
    chk("cfg_rdata", 32'h47, o_cfg_rdata);
    bus(0, 8'h00, 0, 32'h47);
    v = $random(seed) & 32'h1f;
    bus(1, 8'h04, v, 0);
    bus(0, 8'h08, 0, v);
    bus(1, 8'h04, 32'h1f, 0);
    bus(1, 8'h0c, 32'h01, 0);
    bus(1, 8'h10, 32'h02, 0);
    cyc(2);
    chk("host_irq_n", 0, o_host_interrupt_pin_oe_n);
    chk("local_irq", 1, o_local_irq);
    bus(0, 8'h00, 0, 32'h47);
    bus(1, 8'h08, 32'h1f, 0);
    bus(0, 8'h04, 0, 0);
    cyc(2);
    chk("host_irq_n", 1, o_host_interrupt_pin_oe_n);
    $display("test status done");
    @(posedge i_clk);
    i_mst_active <= 1'b1;
    i_mst_read <= 1'b1;
    pulse(0);
    cyc(2);
    chk("perr_oe_n", 0, o_parity_error_pin_oe_n);
    chk("frame_rel", 0, o_frame_release);
    bus(0, 8'h00, 0, 32'h8100_0047);
    bus(0, 8'h04, 0, 32'h02);
    bus(1, 8'h08, 32'h1f, 0);
    bus(1, 8'h00, 32'hf900_0047, 0);
    bus(0, 8'h00, 0, 32'h47);
    i_tgt_active <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      pulse(aev[i]);
      cyc(20);
      if (i < 2)
        chk("local_ready", 1, o_local_ready);
      pulse(9);
      cyc(1);
      chk("local_ready", 0, o_local_ready);
      bus(0, 8'h00, 0, 32'h47 | acs[i]);
      bus(0, 8'h04, 0, ais[i]);
      bus(1, 8'h08, 32'h1f, 0);
      bus(1, 8'h00, 32'hf900_0047, 0);
    end
    $display("test abort done");
    i_mst_addr <= 32'h1003;
    pulse(7);
    pulse(8);
    pulse(8);
    pulse(5);
    cyc(1);
    chk("mst_addr", 32'h1000, o_mst_addr);
    chk("reissue", 32'h1008, o_reissue_addr);
    pulse(6);
    for (i = 0; i < 4; i++)
    begin
      @(posedge i_clk);
      i_tgt_size <= i[1:0];
      cyc(1);
      chk("tgt_be", (1 << (i + 1)) - 1, o_tgt_be);
    end
    @(posedge i_clk);
    i_tgt_addr_lo <= 2'h1;
    i_tgt_size <= 2'h1;
    cyc(1);
    chk("misalign", 1, o_tgt_misaligned);
    $display("test master done");
    @(posedge i_clk);
    i_mst_read <= 1'b0;
    perr_req <= 1'b1;
    cyc(20);
    perr_req <= 1'b0;
    cyc(40);
    bus(0, 8'h00, 0, 32'h0100_0047);
    cfg(32'h147);
    for (i = 0; i < 100 && o_halted !== 1'b1; i++)
      cyc(1);
    chk("halted", 1, o_halted);
    bus(0, 8'h00, 0, 32'h4100_0147);
    pulse(5);
    cyc(2);
    $display("test halt done");
    conclude();
  end
endmodule : tb_pci_err_status
`default_nettype wire
